// ===== inc/i2ca_pkg.sv
// Constants for the transmit-abort cause and DMA enable block.
// Assumes a 32-bit Avalon-MM byte address bus and one 10 MHz clock.
package i2ca_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_ABORT_CAUSE  = 32'h5000_1480;
  localparam logic [31:0] ADDR_DMA_ENABLE   = 32'h5000_1488;
  localparam logic [31:0] ADDR_TX_WATERMARK = 32'h5000_148C;
  localparam logic [31:0] ADDR_RX_WATERMARK = 32'h5000_1490;
  localparam logic [31:0] ADDR_CONTROL      = 32'h5000_14F0;
  localparam logic [31:0] ADDR_IRQ_STATUS   = 32'h5000_14F4;
  localparam logic [31:0] ADDR_IRQ_MASK     = 32'h5000_14F8;

  // Abort cause field positions
  localparam int CAUSE_SEVENBIT_ADDR   = 0;
  localparam int CAUSE_TENBIT_FIRST    = 1;
  localparam int CAUSE_TENBIT_SECOND   = 2;
  localparam int CAUSE_DATA_UNACKED    = 3;
  localparam int CAUSE_GCALL_UNACKED   = 4;
  localparam int CAUSE_GCALL_READ      = 5;
  localparam int CAUSE_HS_CODE_ACKED   = 6;
  localparam int CAUSE_STARTBYTE_ACKED = 7;
  localparam int CAUSE_HS_NORESTART    = 8;
  localparam int CAUSE_SB_NORESTART    = 9;
  localparam int CAUSE_W               = 10;

  // DMA enable field positions
  localparam int DMA_RX_ENABLE_BIT = 0;
  localparam int DMA_TX_ENABLE_BIT = 1;

  // Control register field positions
  localparam int CTL_RESTART_EN_BIT = 0;
  localparam int CTL_GC_OR_SB_BIT   = 1;
  localparam int CTL_CMD_KIND_BIT   = 2;

  // Interrupt status and mask field positions
  localparam int IRQ_ABORT_BIT = 0;
  localparam int IRQ_W         = 1;

  // Values after reset
  localparam logic [15:0] CAUSE_RESET   = 16'h0000;
  localparam logic [1:0]  DMA_EN_RESET  = 2'h0;
  localparam logic [4:0]  WM_RESET      = 5'h00;
  localparam logic [2:0]  CONTROL_RESET = 3'h0;
  localparam logic [0:0]  IRQ_RESET     = 1'h0;

  // Answer to an unmapped read
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Bus slave states
  typedef enum logic [1:0] {
    I2CA_BUS_IDLE   = 2'b01,
    I2CA_BUS_ANSWER = 2'b10
  } i2ca_bus_e;

endpackage : i2ca_pkg

// ===== src/i2ca_abort_dma.sv
// Transmit-abort cause register, DMA channel enables and DMA requests.
// Assumes the bus engine on the same clock reports its events as pulses
// and the FIFOs report their entry counts; software uses Avalon-MM.
`timescale 1ns/1ns

// Notes on behaviour
// [RULE1] START byte without restart sets bit 9, aborts
// [RULE2] Clearing bit 9 with source held: reasserts
// [RULE3] Software removes START byte source before clearing
// [RULE4] High-speed request without restart sets bit 8
// [RULE5] Acknowledged START byte sets bit 7
// [RULE6] Acknowledged high-speed master code sets bit 6
// [RULE7] General call followed by read sets bit 5
// [RULE8] Unacknowledged general call sets bit 4
// [RULE9] Master data byte unacknowledged sets bit 3
// [RULE10] Ten-bit second address byte unacknowledged: bit 2
// [RULE11] Ten-bit first address byte unacknowledged: bit 1
// [RULE12] Seven-bit address unacknowledged sets bit 0
// [RULE13] Transmit DMA enable, bit 1, resets 0
// [RULE14] Receive DMA enable, bit 0, resets 0
// [RULE15] Transmit request when level at/below watermark
// [RULE16] Receive request when level above watermark
// [RULE17] Any new abort cause raises abort interrupt
module i2ca_abort_dma #(
  parameter int LEVEL_W = 6,  // FIFO entry count width
  parameter int WM_W    = 5   // DMA watermark width
) (
  input  wire logic               clk,
  input  wire logic               rst,
  // Avalon-MM slave
  input  wire logic [31:0]        address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [3:0]         byteenable,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  // Events from the bus engine, one-cycle pulses; highspeed_request and tenbit_mode are levels
  input  wire logic               master_start,
  input  wire logic               highspeed_request,
  input  wire logic               tenbit_mode,
  input  wire logic               address_unacked,
  input  wire logic               tenbit_second_unacked,
  input  wire logic               data_unacked,
  input  wire logic               gcall_unacked,
  input  wire logic               gcall_read_next,
  input  wire logic               startbyte_acked,
  input  wire logic               hs_code_acked,
  // FIFO entry counts
  input  wire logic [LEVEL_W-1:0] tx_fifo_level,
  input  wire logic [LEVEL_W-1:0] rx_fifo_level,
  // Outputs
  output logic                    transfer_abort,
  output logic                    dma_tx_req,
  output logic                    dma_rx_req,
  output logic                    irq
);

  // Parameter checks at elaboration
  if (WM_W < 1 || WM_W > 8 || LEVEL_W < WM_W + 1 || LEVEL_W > 16) begin
    : g_bad_width
    $error("i2ca_abort_dma: unsupported LEVEL_W or WM_W");
  end

  // Bus slave state
  i2ca_pkg::i2ca_bus_e      bus_state;
  i2ca_pkg::i2ca_bus_e      next_bus_state;

  // Software visible registers
  logic [i2ca_pkg::CAUSE_W-1:0] abort_cause;      // Sticky abort causes
  logic [1:0]                   dma_channel_enable;
  logic [WM_W-1:0]              transmit_dma_watermark;
  logic [WM_W-1:0]              receive_dma_watermark;
  logic [2:0]                   control;          // Loose config bits
  logic [i2ca_pkg::IRQ_W-1:0]   irq_status;
  logic [i2ca_pkg::IRQ_W-1:0]   irq_mask;
  logic                         sb_reassert;      // Bit 9 returns next

  // Bus decode
  wire                          req         = read | write;
  wire                          accept      = req & ~waitrequest;
  wire                          wr_go       = accept & write & byteenable[0];
  wire                          rd_go       = accept & read;
  wire                          hit_cause   =
    (address == i2ca_pkg::ADDR_ABORT_CAUSE);
  wire                          hit_dma     =
    (address == i2ca_pkg::ADDR_DMA_ENABLE);
  wire                          hit_txwm    =
    (address == i2ca_pkg::ADDR_TX_WATERMARK);
  wire                          hit_rxwm    =
    (address == i2ca_pkg::ADDR_RX_WATERMARK);
  wire                          hit_ctl     =
    (address == i2ca_pkg::ADDR_CONTROL);
  wire                          hit_status  =
    (address == i2ca_pkg::ADDR_IRQ_STATUS);
  wire                          hit_mask    =
    (address == i2ca_pkg::ADDR_IRQ_MASK);

  // Configuration bits seen by the cause logic
  wire restart_en   = control[i2ca_pkg::CTL_RESTART_EN_BIT];
  wire gc_or_sb_sel = control[i2ca_pkg::CTL_GC_OR_SB_BIT];
  wire cmd_kind_sel = control[i2ca_pkg::CTL_CMD_KIND_BIT];

  // START byte selected while repeated start is off
  wire sb_source    = ~restart_en & cmd_kind_sel & gc_or_sb_sel; // RULE1

  // Cause detection, one wire per bit
  logic [i2ca_pkg::CAUSE_W-1:0] cause_set;
  assign cause_set[i2ca_pkg::CAUSE_SB_NORESTART] =
    (master_start & sb_source) | sb_reassert;                  // RULE1
  assign cause_set[i2ca_pkg::CAUSE_HS_NORESTART] =
    master_start & highspeed_request & ~restart_en;            // RULE4
  assign cause_set[i2ca_pkg::CAUSE_STARTBYTE_ACKED] =
    startbyte_acked;                                           // RULE5
  assign cause_set[i2ca_pkg::CAUSE_HS_CODE_ACKED] =
    hs_code_acked;                                             // RULE6
  assign cause_set[i2ca_pkg::CAUSE_GCALL_READ] =
    gcall_read_next;                                           // RULE7
  assign cause_set[i2ca_pkg::CAUSE_GCALL_UNACKED] =
    gcall_unacked;                                             // RULE8
  assign cause_set[i2ca_pkg::CAUSE_DATA_UNACKED] =
    data_unacked;                                              // RULE9
  assign cause_set[i2ca_pkg::CAUSE_TENBIT_SECOND] =
    tenbit_second_unacked & tenbit_mode;                       // RULE10
  assign cause_set[i2ca_pkg::CAUSE_TENBIT_FIRST] =
    address_unacked & tenbit_mode;                             // RULE11
  assign cause_set[i2ca_pkg::CAUSE_SEVENBIT_ADDR] =
    address_unacked & ~tenbit_mode;                            // RULE12

  // A read of the cause register clears it
  wire cause_clear = rd_go & hit_cause;
  wire any_cause   = |cause_set;                               // RULE17

  // Read data selection, narrow fields in the low bits
  wire [31:0] rd_value =
    hit_cause  ? {22'h00_0000, abort_cause} :
    hit_dma    ? {30'h0000_0000, dma_channel_enable} :
    hit_txwm   ? {{(32 - WM_W){1'b0}}, transmit_dma_watermark} :
    hit_rxwm   ? {{(32 - WM_W){1'b0}}, receive_dma_watermark} :
    hit_ctl    ? {29'h0000_0000, control} :
    hit_status ? {31'h0000_0000, irq_status} :
    hit_mask   ? {31'h0000_0000, irq_mask} :
    i2ca_pkg::UNMAPPED_READ;

  // DMA request conditions
  wire [LEVEL_W-1:0] tx_wm_ext = LEVEL_W'(transmit_dma_watermark);
  wire [LEVEL_W-1:0] rx_wm_ext = LEVEL_W'(receive_dma_watermark);
  wire next_dma_tx_req =
    dma_channel_enable[i2ca_pkg::DMA_TX_ENABLE_BIT] &
    (tx_fifo_level <= tx_wm_ext);                              // RULE15
  wire next_dma_rx_req =
    dma_channel_enable[i2ca_pkg::DMA_RX_ENABLE_BIT] &
    (rx_fifo_level >= rx_wm_ext + LEVEL_W'(1));                // RULE16

  // Bus slave next state: one wait cycle, then one answer cycle
  always_comb begin
    next_bus_state = bus_state;
    unique case (bus_state)
      i2ca_pkg::I2CA_BUS_IDLE: begin
        if (req) begin
          next_bus_state = i2ca_pkg::I2CA_BUS_ANSWER;
        end
      end
      i2ca_pkg::I2CA_BUS_ANSWER: begin
        next_bus_state = i2ca_pkg::I2CA_BUS_IDLE;
      end
      default: begin
        next_bus_state = i2ca_pkg::I2CA_BUS_IDLE;
      end
    endcase
  end

  // Bus state, waitrequest and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_state   <= i2ca_pkg::I2CA_BUS_IDLE;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      bus_state   <= next_bus_state;
      // Low for exactly the cycle after a request is seen
      waitrequest <= ~(req & (bus_state == i2ca_pkg::I2CA_BUS_IDLE));
      if (req && bus_state == i2ca_pkg::I2CA_BUS_IDLE) begin
        readdata <= rd_value;
      end
    end
  end

  // Sticky causes: a new cause wins over the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      abort_cause <= i2ca_pkg::CAUSE_RESET[i2ca_pkg::CAUSE_W-1:0];
    end else if (cause_clear) begin
      abort_cause <= cause_set;
    end else begin
      abort_cause <= abort_cause | cause_set;
    end
  end

  // Bit 9 cleared with its source still present drops for one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      sb_reassert <= 1'b0;
    end else begin
      sb_reassert <= cause_clear & sb_source &
                     abort_cause[i2ca_pkg::CAUSE_SB_NORESTART]; // RULE2
    end
  end

  // Abort strobe to the transfer engine
  always_ff @(posedge clk) begin
    if (rst) begin
      transfer_abort <= 1'b0;
    end else begin
      transfer_abort <= any_cause;                             // RULE1
    end
  end

  // Software written registers
  always_ff @(posedge clk) begin
    if (rst) begin
      dma_channel_enable     <= i2ca_pkg::DMA_EN_RESET;
      transmit_dma_watermark <= i2ca_pkg::WM_RESET[WM_W-1:0];
      receive_dma_watermark  <= i2ca_pkg::WM_RESET[WM_W-1:0];
      control                <= i2ca_pkg::CONTROL_RESET;
      irq_mask               <= i2ca_pkg::IRQ_RESET;
    end else if (wr_go) begin
      if (hit_dma) begin
        dma_channel_enable <= writedata[1:0];                  // RULE13 RULE14
      end
      if (hit_txwm) begin
        transmit_dma_watermark <= writedata[WM_W-1:0];
      end
      if (hit_rxwm) begin
        receive_dma_watermark <= writedata[WM_W-1:0];
      end
      if (hit_ctl) begin
        control <= writedata[2:0];
      end
      if (hit_mask) begin
        irq_mask <= writedata[0:0];
      end
    end
  end

  // Interrupt status: set wins over read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= i2ca_pkg::IRQ_RESET;
    end else if (any_cause) begin
      irq_status[i2ca_pkg::IRQ_ABORT_BIT] <= 1'b1;             // RULE17
    end else if (rd_go && hit_status) begin
      irq_status <= i2ca_pkg::IRQ_RESET;
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      irq        <= 1'b0;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end else begin
      irq        <= |(irq_status & irq_mask);
      dma_tx_req <= next_dma_tx_req;                           // RULE15
      dma_rx_req <= next_dma_rx_req;                           // RULE16
    end
  end

  // Checks beside the logic
  a_sbyte_sets_bit9: assert property ( // RULE1
    @(posedge clk) disable iff (rst)
    master_start && sb_source |=>
      abort_cause[i2ca_pkg::CAUSE_SB_NORESTART] && transfer_abort)
    else $error("start byte without restart not flagged");

  a_bit9_returns: assert property ( // RULE2
    @(posedge clk) disable iff (rst)
    cause_clear && sb_source && !master_start &&
    abort_cause[i2ca_pkg::CAUSE_SB_NORESTART] && $stable(control) |=>
      !abort_cause[i2ca_pkg::CAUSE_SB_NORESTART] ##1
      abort_cause[i2ca_pkg::CAUSE_SB_NORESTART])
    else $error("bit 9 did not return after one cycle");

  a_hs_sets_bit8: assert property ( // RULE4
    @(posedge clk) disable iff (rst)
    master_start && highspeed_request && !restart_en |=>
      abort_cause[i2ca_pkg::CAUSE_HS_NORESTART])
    else $error("high-speed without restart not flagged");

  a_ack_causes: assert property ( // RULE5
    @(posedge clk) disable iff (rst)
    startbyte_acked || hs_code_acked |=>
      abort_cause[7:6] == {$past(startbyte_acked), $past(hs_code_acked)}
      || $past(abort_cause[7:6] != 2'h0) && !$past(cause_clear))
    else $error("acknowledge cause mismatch");

  // Each acknowledge or no-acknowledge lands in its own bit
  a_hs_ack_bit6: assert property ( // RULE6
    @(posedge clk) disable iff (rst)
    hs_code_acked |=> abort_cause[i2ca_pkg::CAUSE_HS_CODE_ACKED])
    else $error("high-speed code acknowledge not flagged");

  a_gcall_causes: assert property ( // RULE7
    @(posedge clk) disable iff (rst)
    gcall_read_next |=> abort_cause[i2ca_pkg::CAUSE_GCALL_READ]
    ##0 transfer_abort)
    else $error("general call read not flagged");

  a_gcall_noack_bit4: assert property ( // RULE8
    @(posedge clk) disable iff (rst)
    gcall_unacked |=> abort_cause[i2ca_pkg::CAUSE_GCALL_UNACKED])
    else $error("unacknowledged general call not flagged");

  a_data_noack_bit3: assert property ( // RULE9
    @(posedge clk) disable iff (rst)
    data_unacked |=> abort_cause[i2ca_pkg::CAUSE_DATA_UNACKED])
    else $error("unacknowledged data byte not flagged");

  // Second address byte only counts in ten-bit mode
  a_tenbit_second: assert property ( // RULE10
    @(posedge clk) disable iff (rst)
    tenbit_second_unacked && tenbit_mode |=>
      abort_cause[i2ca_pkg::CAUSE_TENBIT_SECOND])
    else $error("ten-bit second byte cause not flagged");

  a_addr_select: assert property ( // RULE12
    @(posedge clk) disable iff (rst)
    address_unacked && !tenbit_mode && !cause_clear |=>
      abort_cause[i2ca_pkg::CAUSE_SEVENBIT_ADDR] &&
      abort_cause[i2ca_pkg::CAUSE_TENBIT_FIRST] ==
      $past(abort_cause[i2ca_pkg::CAUSE_TENBIT_FIRST]))
    else $error("address cause in wrong bit");

  a_dma_enable_wr: assert property ( // RULE13
    @(posedge clk) disable iff (rst)
    wr_go && hit_dma |=> dma_channel_enable == $past(writedata[1:0]))
    else $error("DMA enable write lost");

  a_tx_dma_req: assert property ( // RULE15
    @(posedge clk) disable iff (rst)
    ##1 dma_tx_req == $past(dma_channel_enable[1] &&
      tx_fifo_level <= tx_wm_ext))
    else $error("transmit DMA request wrong");

  a_rx_dma_req: assert property ( // RULE16
    @(posedge clk) disable iff (rst)
    dma_channel_enable[0] && rx_fifo_level == LEVEL_W'(0) |=> !dma_rx_req)
    else $error("receive DMA request on empty FIFO");

  a_abort_irq: assert property ( // RULE17
    @(posedge clk) disable iff (rst)
    any_cause && irq_mask[0] |=> ##1 irq)
    else $error("abort interrupt not raised");

  a_bus_answer: assert property (@(posedge clk) disable iff (rst)
    req && waitrequest && bus_state == i2ca_pkg::I2CA_BUS_IDLE |=>
      !waitrequest ##1 waitrequest)
    else $error("bus answer timing wrong");

endmodule : i2ca_abort_dma

// ===== verif/i2ca_bus_partner.sv
// Model of the bus engine and the remote masters and slaves on the bus.
// Assumes one event is asked for at a time, on the block's own clock.
`timescale 1ns/1ns
module i2ca_bus_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fire,   // Ask for one bus event
  input  wire logic [2:0] kind,   // Which event to report
  input  wire logic [3:0] dly,    // Cycles the far side takes
  output logic      [7:0] events  // One-cycle event pulses
);
  logic       armed;  // Event pending
  logic [3:0] cnt;    // Remaining wait
  logic [2:0] held;   // Event latched at the request
  // Pulses last one cycle; slow answers leave idle gaps
  always @(posedge clk) begin
    events <= 8'h00;
    if (rst) begin
      armed <= 1'b0;
    end else if (fire) begin
      armed <= 1'b1;
      cnt <= dly;
      held <= kind;
    end else if (armed) begin
      // Latched event (start, ack, no-ack or read) reported once the wait runs out
      if (cnt == 4'h0) begin
        events[held] <= 1'b1;
        armed <= 1'b0;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : i2ca_bus_partner

// ===== verif/i2ca_abort_dma_bench.sv
// Self-checking bench for the abort cause and DMA enable block.
// Assumes the Avalon slave answers with waitrequest; one clock domain.
`timescale 1ns/1ns
module i2ca_abort_dma_bench;
  typedef struct packed {
    logic [2:0]  ctl;   // Control register value
    logic        hs;    // High-speed request level
    logic        ten;   // Ten-bit addressing level
    logic [2:0]  kind;  // Event asked of the partner
    logic [3:0]  dly;   // Partner delay
    logic [15:0] cause; // Expected cause word
  } i2ca_row_s;
  logic        clk, rst, read, write, fire, hs, ten;
  logic [31:0] address, writedata, readdata, rd;
  logic [3:0]  byteenable, dly;
  logic [2:0]  kind;
  logic [7:0]  events;
  logic [5:0]  tx_lvl, rx_lvl;
  logic        waitrequest, transfer_abort, dma_tx_req, dma_rx_req, irq;
  int          fails, total_checks, cycles, aborts, n0;
  i2ca_row_s   rows [11];
  i2ca_bus_partner i_i2ca_bus_partner (.clk(clk), .rst(rst), .fire(fire),
    .kind(kind), .dly(dly), .events(events));
  i2ca_abort_dma i_i2ca_abort_dma (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .master_start(events[0]), .highspeed_request(hs), .tenbit_mode(ten),
    .address_unacked(events[1]), .tenbit_second_unacked(events[2]),
    .data_unacked(events[3]), .gcall_unacked(events[4]),
    .gcall_read_next(events[5]), .hs_code_acked(events[6]),
    .startbyte_acked(events[7]), .tx_fifo_level(tx_lvl),
    .rx_fifo_level(rx_lvl), .transfer_abort(transfer_abort),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .irq(irq));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Abort pulses counted; a stuck pulse shows as extra counts
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (transfer_abort === 1'b1) begin
      aborts <= aborts + 1;
    end
    // Hang guard
    if (cycles == 20000) begin
      fails = fails + 1;
      results();
    end
  end
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One Avalon access; holds until waitrequest is sampled low
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] d,
                     logic [3:0] be);
    @(posedge clk);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rdchk(string name, logic [31:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(name, rd, exp);
  endtask : rdchk
  // Ask the partner for one event, then let it settle
  task automatic raise(logic [2:0] k, logic [3:0] d);
    @(posedge clk);
    fire <= 1'b1;
    kind <= k;
    dly <= d;
    @(posedge clk);
    fire <= 1'b0;
    repeat (int'(d) + 5) @(posedge clk);
  endtask : raise
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    {read, write, fire, hs, ten, kind, dly} = '0;
    {address, writedata, tx_lvl, rx_lvl} = '0;
    {fails, total_checks, cycles, aborts} = '0;
    byteenable = 4'hF;
    rst = 1'b1;
    rows[0]  = '{3'h0, 1'b0, 1'b0, 3'h1, 4'h0, 16'h0001};
    rows[1]  = '{3'h0, 1'b0, 1'b1, 3'h1, 4'h3, 16'h0002};
    rows[2]  = '{3'h0, 1'b0, 1'b1, 3'h2, 4'h0, 16'h0004};
    rows[3]  = '{3'h0, 1'b0, 1'b0, 3'h3, 4'h5, 16'h0008};
    rows[4]  = '{3'h0, 1'b0, 1'b0, 3'h4, 4'h0, 16'h0010};
    rows[5]  = '{3'h0, 1'b0, 1'b0, 3'h5, 4'h1, 16'h0020};
    rows[6]  = '{3'h0, 1'b0, 1'b0, 3'h6, 4'h0, 16'h0040};
    rows[7]  = '{3'h0, 1'b0, 1'b0, 3'h7, 4'h2, 16'h0080};
    rows[8]  = '{3'h0, 1'b1, 1'b0, 3'h0, 4'h0, 16'h0100};
    rows[9]  = '{3'h6, 1'b0, 1'b0, 3'h0, 4'h4, 16'h0200};
    rows[10] = '{3'h7, 1'b1, 1'b0, 3'h0, 4'h0, 16'h0000};
    repeat (4) @(posedge clk);
    chk("waitrequest in reset", {31'h0, waitrequest}, 32'h1);
    chk("readdata in reset", readdata, 32'h0);
    rst <= 1'b0;
    rdchk("cause reset", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h0);
    rdchk("dma reset", i2ca_pkg::ADDR_DMA_ENABLE, 32'h0);
    // Table of causes, mask off
    foreach (rows[i]) begin
      bus(1'b1, i2ca_pkg::ADDR_CONTROL, {29'h0, rows[i].ctl}, 4'hF);
      hs <= rows[i].hs;
      ten <= rows[i].ten;
      n0 = aborts;
      raise(rows[i].kind, rows[i].dly);
      chk("abort pulses", aborts, n0 + (rows[i].cause != 0));
      // Source removed before the clearing read
      bus(1'b1, i2ca_pkg::ADDR_CONTROL, 32'h0, 4'hF);
      rdchk("cause", i2ca_pkg::ADDR_ABORT_CAUSE, rows[i].cause);
      rdchk("cause cleared", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h0);
      rdchk("irq status", i2ca_pkg::ADDR_IRQ_STATUS,
            {31'h0, rows[i].cause != 0});
      chk("irq masked", {31'h0, irq}, 32'h0);
    end
    // Last row leaves high-speed up; drop it so only bit 9 can follow
    hs <= 1'b0;
    // Clearing bit 9 while its source still holds
    bus(1'b1, i2ca_pkg::ADDR_CONTROL, 32'h6, 4'hF);
    raise(3'h0, 4'h0);
    rdchk("sb first read", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h200);
    rdchk("sb reasserted", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h200);
    bus(1'b1, i2ca_pkg::ADDR_CONTROL, 32'h0, 4'hF);
    rdchk("sb fixed", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h200);
    rdchk("sb cleared", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h0);
    rdchk("sb irq status", i2ca_pkg::ADDR_IRQ_STATUS, 32'h1);
    // Interrupt unmasked, then cleared by reading status
    bus(1'b1, i2ca_pkg::ADDR_IRQ_MASK, 32'h1, 4'hF);
    raise(3'h3, 4'h0);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rdchk("cause data", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h8);
    rdchk("irq status set", i2ca_pkg::ADDR_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // Read-only, unmapped and lane-gated accesses
    bus(1'b1, i2ca_pkg::ADDR_ABORT_CAUSE, 32'h3FF, 4'hF);
    rdchk("cause read only", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h0);
    rdchk("unmapped", 32'h5000_1400, i2ca_pkg::UNMAPPED_READ);
    bus(1'b1, i2ca_pkg::ADDR_DMA_ENABLE, 32'h3, 4'h0);
    rdchk("dma lane off", i2ca_pkg::ADDR_DMA_ENABLE, 32'h0);
    bus(1'b1, i2ca_pkg::ADDR_DMA_ENABLE, 32'h2, 4'hF);
    rdchk("dma tx only", i2ca_pkg::ADDR_DMA_ENABLE, 32'h2);
    bus(1'b1, i2ca_pkg::ADDR_DMA_ENABLE, 32'h3, 4'hF);
    rdchk("dma both", i2ca_pkg::ADDR_DMA_ENABLE, 32'h3);
    // Watermark boundaries
    bus(1'b1, i2ca_pkg::ADDR_TX_WATERMARK, 32'h5, 4'hF);
    bus(1'b1, i2ca_pkg::ADDR_RX_WATERMARK, 32'h3, 4'hF);
    tx_lvl <= 6'h05;
    rx_lvl <= 6'h03;
    repeat (3) @(posedge clk);
    chk("tx req at mark", {31'h0, dma_tx_req}, 32'h1);
    chk("rx req at mark", {31'h0, dma_rx_req}, 32'h0);
    tx_lvl <= 6'h06;
    rx_lvl <= 6'h04;
    repeat (3) @(posedge clk);
    chk("tx req above", {31'h0, dma_tx_req}, 32'h0);
    chk("rx req above", {31'h0, dma_rx_req}, 32'h1);
    tx_lvl <= 6'h00;
    bus(1'b1, i2ca_pkg::ADDR_DMA_ENABLE, 32'h0, 4'hF);
    repeat (3) @(posedge clk);
    chk("tx req off", {31'h0, dma_tx_req}, 32'h0);
    chk("rx req off", {31'h0, dma_rx_req}, 32'h0);
    // Reset in mid-run, with enables, a cause and the interrupt live
    bus(1'b1, i2ca_pkg::ADDR_DMA_ENABLE, 32'h3, 4'hF);
    raise(3'h4, 4'h0);
    chk("irq before reset", {31'h0, irq}, 32'h1);
    chk("tx req before reset", {31'h0, dma_tx_req}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("waitrequest mid reset", {31'h0, waitrequest}, 32'h1);
    chk("irq mid reset", {31'h0, irq}, 32'h0);
    chk("tx req mid reset", {31'h0, dma_tx_req}, 32'h0);
    rst <= 1'b0;
    rdchk("cause re-reset", i2ca_pkg::ADDR_ABORT_CAUSE, 32'h0);
    rdchk("dma re-reset", i2ca_pkg::ADDR_DMA_ENABLE, 32'h0);
    results();
  end
endmodule : i2ca_abort_dma_bench
